// ---- logic/drs_dev.sv ----
// Device end: decodes 16-bit frames from the link into per-channel range
// settings, the toggle mirror, soft reset and watchdog keep-alive.
// Assumes link pins are synchronous to I_CLK_SYS and sclk is slower than
// half the system clock so each edge is seen.
// Frames with a prefix other than 100 or 111 are passed over.
// Limitation: no readback path, so the toggle mirror is an output only.
//
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "drs_params.svh"

module drs_dev
  import drs_pkg::*;
#(
  parameter int unsigned WDOG_TO_CYC = `DRS_WDOG_TO_CYC
)
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  input wire logic I_CE,
  input wire logic I_WDOG_EN,
  drs_link_if.dev dv,
  output logic [3*`DRS_NCH-1:0] O_RANGE_CODE,
  output logic [`DRS_NCH-1:0] O_OVRANGE_EN,
  output logic [`DRS_NCH-1:0] O_OVRANGE_ACT,
  output logic [`DRS_NCH-1:0] O_CURRENT_MODE,
  output logic O_TOGGLE,
  output logic O_SOFT_RESET,
  output logic O_FAULT
);

  // Idle link levels are high, so the edge trackers start high
  // A low start would fake a select rise (frame end) at the first edge
  localparam drs_dev_st_t DEV_RST = '{
    sclk_q: 1'b1,
    sync_q: 1'b1,
    sh: '0,
    cnt: '0,
    rng: {`DRS_NCH{`DRS_RNG_RST}},
    ovr: {`DRS_NCH{`DRS_OVR_RST}},
    ovr_act: '0,
    curr: '0,
    tog: `DRS_TOG_RST,
    kick: 1'b0,
    srst: 1'b0
  };

  // Bits in one valid frame
  localparam logic [4:0] FRAME_CNT = 5'(`DRS_FRAME_W);

  // Present and next state of this end
  drs_dev_st_t s;
  drs_dev_st_t next_s;
  // Watchdog fault, shared by the pin and the user output
  logic wd_fault;

  // True for the four voltage ranges
  function automatic logic rng_is_volt(input logic [2:0] c);
    rng_is_volt = (c == RNG_V0_5) || (c == RNG_V0_10) ||
                  (c == RNG_VPM5) || (c == RNG_VPM10);
  endfunction : rng_is_volt

  // True for the three current ranges; code 111 is neither
  function automatic logic rng_is_curr(input logic [2:0] c);
    rng_is_curr = (c == RNG_I4_20) || (c == RNG_I0_20) ||
                  (c == RNG_I0_24);
  endfunction : rng_is_curr

  // Frame class test on the three leading bits
  function automatic logic has_prefix(input logic [`DRS_FRAME_W-1:0] f,
                                      input logic [2:0] p);
    has_prefix = (f[`DRS_PFX_HI:`DRS_PFX_LO] == p);
  endfunction : has_prefix

  // Frame capture, decode and the derived per-channel outputs
  // Decoded flags come from next_s so they move with the codes
  always_comb
  begin
    logic fall;
    logic done;
    logic [1:0] ch;
    logic [11:0] code;
    fall = 1'b0;
    done = 1'b0;
    ch = '0;
    code = '0;
    next_s = s;
    next_s.kick = 1'b0;
    next_s.srst = 1'b0;
    // Sample flops for edge detection
    next_s.sclk_q = dv.sclk;
    next_s.sync_q = dv.sync_b;
    fall = s.sclk_q && !dv.sclk;

    // Shift on falling sclk while the frame is open
    if (!dv.sync_b)
    begin
      if (s.sync_q)
      begin
        // A falling select restarts the bit count
        next_s.cnt = '0;
      end
      else if (fall)
      begin
        next_s.sh = {s.sh[`DRS_FRAME_W-2:0], dv.sdi};
        // Saturate one past a full frame so long frames are dropped
        if (s.cnt <= FRAME_CNT)
          next_s.cnt = 5'(s.cnt + 5'h1);
      end
    end

    // A frame counts only if exactly sixteen bits arrived
    // Short or long frames leave every setting untouched
    done = dv.sync_b && !s.sync_q && (s.cnt == FRAME_CNT);
    ch = s.sh[`DRS_CH_HI:`DRS_CH_LO];
    code = s.sh[`DRS_CODE_HI:0];

    if (done)
    begin
      if (has_prefix(s.sh, `DRS_PFX_SWCMD))
      begin
        // Command frame: toggle first, then the two keys
        next_s.tog = s.sh[`DRS_TOG_BIT];
        if (code == `DRS_KEY_RESET)
        begin
          // Full reset of all decoded state, watchdog included
          next_s.rng = {`DRS_NCH{`DRS_RNG_RST}};
          next_s.ovr = {`DRS_NCH{`DRS_OVR_RST}};
          next_s.tog = `DRS_TOG_RST;
          next_s.srst = 1'b1;
        end
        else if (code == `DRS_KEY_KICK)
        begin
          next_s.kick = 1'b1;
        end
        // Any other code leaves only the toggle changed
      end
      else if (has_prefix(s.sh, `DRS_PFX_RANGE))
      begin
        // Range frame: channel 12:11, enable bit 3, code 2:0
        next_s.rng[ch] = s.sh[`DRS_RNG_HI:0];
        next_s.ovr[ch] = s.sh[`DRS_OVR_BIT];
      end
    end

    // Registered decode keeps outputs glitch free
    // Code 111 is neither class: no overrange, no current
    for (int i = 0; i < `DRS_NCH; i++)
    begin
      next_s.ovr_act[i] = next_s.ovr[i] &&
                          rng_is_volt(next_s.rng[i]);
      next_s.curr[i] = rng_is_curr(next_s.rng[i]);
    end
  end

  // State register; CE low freezes every flop
  // The soft reset path reuses the same reset macros
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
      s <= DEV_RST;
    else if (I_CE)
      s <= next_s;
  end

  // Soft reset also restarts the watchdog and clears its fault
  // The restart lands one cycle after the decode, well inside any timeout
  drs_wdog #(
    .TIMEOUT_CYC(WDOG_TO_CYC)
  ) u_wdog (
    .i_clk(I_CLK_SYS),
    .i_rst_b(I_RST_B),
    .i_ce(I_CE),
    .i_en(I_WDOG_EN),
    .i_kick(s.kick | s.srst),
    .o_fault(wd_fault)
  );

  // Alert is active low on the link
  assign dv.alert_b = !wd_fault;

  // User-side outputs, all straight from flops
  // O_FAULT repeats the pin for logic that does not watch the link
  assign O_RANGE_CODE = s.rng;
  assign O_OVRANGE_EN = s.ovr;
  assign O_OVRANGE_ACT = s.ovr_act;
  assign O_CURRENT_MODE = s.curr;
  assign O_TOGGLE = s.tog;
  assign O_SOFT_RESET = s.srst;
  assign O_FAULT = wd_fault;

endmodule : drs_dev

`default_nettype wire

// ---- logic/drs_params.svh ----
// Constants shared by the range/command decode design: frame layout,
// command keys, reset values, timing and the host register map.
// Assumes a 100 MHz system clock on both ends of the link.
`ifndef DRS_PARAMS_SVH
`define DRS_PARAMS_SVH

// Frame layout, 16 bits shifted MSB first
`define DRS_FRAME_W 16
`define DRS_PFX_HI 15
`define DRS_PFX_LO 13
`define DRS_PFX_SWCMD 3'h4
`define DRS_PFX_RANGE 3'h7
`define DRS_TOG_BIT 12
`define DRS_CODE_HI 11
`define DRS_CH_HI 12
`define DRS_CH_LO 11
`define DRS_OVR_BIT 3
`define DRS_RNG_HI 2
`define DRS_NCH 4

// Command codes carried in the low twelve bits
`define DRS_KEY_RESET 12'h555
`define DRS_KEY_KICK 12'h195

// Reset values
`define DRS_RNG_RST 3'h0
`define DRS_OVR_RST 1'b0
`define DRS_TOG_RST 1'b0

// Timing
`define DRS_CLK_NS 10
`define DRS_WDOG_TO_US 1000
`define DRS_WDOG_TO_CYC ((`DRS_WDOG_TO_US * 1000) / `DRS_CLK_NS)
`define DRS_SCLK_HALF_NS 20
`define DRS_SCLK_HALF_CYC \
  ((`DRS_SCLK_HALF_NS + `DRS_CLK_NS - 1) / `DRS_CLK_NS)

// Host register map (byte offsets) and fields
`define DRS_A_CMD 8'h00
`define DRS_A_STAT 8'h04
`define DRS_A_IRQ 8'h08
`define DRS_A_MASK 8'h0c
`define DRS_ST_BUSY 0
`define DRS_ST_ALERT 1
`define DRS_IRQ_DONE 0
`define DRS_IRQ_ALERT 1
`define DRS_IRQ_W 2

`endif

// ---- logic/drs_pkg.sv ----
// Types for the range/command decode design.
// Assumes drs_params.svh is on the include path.
`default_nettype none
`include "drs_params.svh"

package drs_pkg;

  // Output range codes
  typedef enum logic [2:0] {
    RNG_V0_5 = 3'h0,
    RNG_V0_10 = 3'h1,
    RNG_VPM5 = 3'h2,
    RNG_VPM10 = 3'h3,
    RNG_I4_20 = 3'h4,
    RNG_I0_20 = 3'h5,
    RNG_I0_24 = 3'h6
  } drs_range_t;

  // Host link sequencer states
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_SETUP = 3'b010,
    HS_LOW = 3'b100
  } drs_hstate_t;

  // Device state
  typedef struct packed {
    logic sclk_q;
    logic sync_q;
    logic [`DRS_FRAME_W-1:0] sh;
    logic [4:0] cnt;
    logic [`DRS_NCH-1:0][2:0] rng;
    logic [`DRS_NCH-1:0] ovr;
    logic [`DRS_NCH-1:0] ovr_act;
    logic [`DRS_NCH-1:0] curr;
    logic tog;
    logic kick;
    logic srst;
  } drs_dev_st_t;

  // Watchdog state
  typedef struct packed {
    logic [31:0] cnt;
    logic fault;
  } drs_wdog_st_t;

  // Host state
  typedef struct packed {
    drs_hstate_t st;
    logic [7:0] div;
    logic [3:0] cnt;
    logic [`DRS_FRAME_W-1:0] sh;
    logic sclk;
    logic sync_b;
    logic sdi;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic [`DRS_IRQ_W-1:0] irq_stat;
    logic [`DRS_IRQ_W-1:0] irq_mask;
    logic alert_q;
  } drs_host_st_t;

endpackage : drs_pkg

`default_nettype wire

// ---- logic/drs_link_if.sv ----
// Serial link between the host controller and the DAC command decode.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
`default_nettype none

interface drs_link_if;
  logic sclk;
  logic sync_b;
  logic sdi;
  logic alert_b;

  modport host (output sclk, output sync_b, output sdi, input alert_b);
  modport dev (input sclk, input sync_b, input sdi, output alert_b);
endinterface : drs_link_if

`default_nettype wire

// ---- logic/drs_wdog.sv ----
// Keep-alive watchdog: counts while enabled, flags a fault on timeout.
// Assumes the kick input is a one-cycle pulse in the same clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "drs_params.svh"

module drs_wdog
  import drs_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `DRS_WDOG_TO_CYC
)
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_en,
  input wire logic i_kick,
  output logic o_fault
);

  drs_wdog_st_t s;
  drs_wdog_st_t next_s;

  // Disabled watchdog neither counts nor faults
  always_comb
  begin
    next_s = s;
    if (!i_en)
    begin
      next_s = '0;
    end
    else if (i_kick)
    begin
      next_s = '0;
    end
    else if (s.cnt >= 32'(TIMEOUT_CYC - 1))
    begin
      next_s.fault = 1'b1;
    end
    else
    begin
      next_s.cnt = s.cnt + 32'h1;
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      s <= '0;
    else if (i_ce)
      s <= next_s;
  end

  assign o_fault = s.fault;

endmodule : drs_wdog

`default_nettype wire

// ---- logic/drs_host.sv ----
// Host end: an AHB-Lite slave whose command register sends one 16-bit
// frame over the link; status, sticky interrupt flags and a mask.
// Assumes one master, zero-wait-state answers, word transfers only.
`timescale 1ns/100ps
`default_nettype none
`include "drs_params.svh"

module drs_host
  import drs_pkg::*;
#(
  parameter int unsigned HALF_CYC = `DRS_SCLK_HALF_CYC
)
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  input wire logic I_CE,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic O_IRQ,
  drs_link_if.host hl
);

  // Alert sample starts at the pin's idle level, so STAT is clean at once
  localparam drs_host_st_t HOST_RST = '{
    st: HS_IDLE,
    sclk: 1'b1,
    sync_b: 1'b1,
    alert_q: 1'b1,
    default: '0
  };
  localparam logic [7:0] HALF_END = 8'(HALF_CYC - 1);
  localparam logic [3:0] LAST_BIT = 4'(`DRS_FRAME_W - 1);

  drs_host_st_t s;
  drs_host_st_t next_s;

  // Bus, sequencer and interrupt flags in one pass
  always_comb
  begin
    logic acc;
    logic [`DRS_IRQ_W-1:0] set;
    logic [`DRS_IRQ_W-1:0] clr;
    acc = I_HSEL && I_HTRANS[1] && I_HREADY && (I_HSIZE == 3'h2);
    set = '0;
    clr = '0;
    next_s = s;
    next_s.alert_q = hl.alert_b;
    next_s.ap_wr = acc && I_HWRITE;
    next_s.ap_addr = I_HADDR[7:0];
    next_s.rdata = '0;

    // Read data is prepared in the address phase
    if (acc && !I_HWRITE)
    begin
      unique case (I_HADDR[7:0])
        `DRS_A_STAT:
          next_s.rdata = 32'({!s.alert_q, s.st != HS_IDLE});
        `DRS_A_IRQ: next_s.rdata = 32'(s.irq_stat);
        `DRS_A_MASK: next_s.rdata = 32'(s.irq_mask);
        default: next_s.rdata = '0;
      endcase
    end

    // Alert going low is an event
    set[`DRS_IRQ_ALERT] = s.alert_q && !hl.alert_b;

    // Link sequencer: sdi changes with sclk high, device samples on fall
    unique case (s.st)
      HS_IDLE:
      begin
        // A command written while busy is dropped
        if (s.ap_wr && s.ap_addr == `DRS_A_CMD)
        begin
          next_s.sh = I_HWDATA[`DRS_FRAME_W-1:0];
          next_s.sdi = I_HWDATA[`DRS_FRAME_W-1];
          next_s.sync_b = 1'b0;
          next_s.cnt = '0;
          next_s.div = '0;
          next_s.st = HS_SETUP;
        end
      end
      HS_SETUP:
      begin
        next_s.div = 8'(s.div + 8'h1);
        if (s.div == HALF_END)
        begin
          next_s.div = '0;
          next_s.sclk = 1'b0;
          next_s.st = HS_LOW;
        end
      end
      HS_LOW:
      begin
        next_s.div = 8'(s.div + 8'h1);
        if (s.div == HALF_END)
        begin
          next_s.div = '0;
          next_s.sclk = 1'b1;
          if (s.cnt == LAST_BIT)
          begin
            next_s.sync_b = 1'b1;
            next_s.st = HS_IDLE;
            set[`DRS_IRQ_DONE] = 1'b1;
          end
          else
          begin
            next_s.cnt = 4'(s.cnt + 4'h1);
            next_s.sh = {s.sh[`DRS_FRAME_W-2:0], 1'b0};
            next_s.sdi = s.sh[`DRS_FRAME_W-2];
            next_s.st = HS_SETUP;
          end
        end
      end
    endcase

    // Register writes in the data phase
    if (s.ap_wr && s.ap_addr == `DRS_A_IRQ)
      clr = I_HWDATA[`DRS_IRQ_W-1:0];
    if (s.ap_wr && s.ap_addr == `DRS_A_MASK)
      next_s.irq_mask = I_HWDATA[`DRS_IRQ_W-1:0];
    // A new event beats a clear in the same cycle
    next_s.irq_stat = (s.irq_stat & ~clr) | set;
  end

  // State register
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
      s <= HOST_RST;
    else if (I_CE)
      s <= next_s;
  end

  assign O_HRDATA = s.rdata;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;
  assign O_IRQ = |(s.irq_stat & s.irq_mask);
  assign hl.sclk = s.sclk;
  assign hl.sync_b = s.sync_b;
  assign hl.sdi = s.sdi;

endmodule : drs_host

`default_nettype wire

// ---- test/drs_assertions.sv ----
// Checker for the host/device link and the device end's settings.
// Assumes one 100 MHz clock, async active-low reset, 2-cycle half sclk.
`timescale 1ns/100ps
`default_nettype none

module drs_assertions
  import drs_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  input wire logic I_CE,
  input wire logic I_WDOG_EN,
  input wire logic sclk,
  input wire logic sync_b,
  input wire logic alert_b,
  input wire logic [11:0] O_RANGE_CODE,
  input wire logic [3:0] O_OVRANGE_EN,
  input wire logic [3:0] O_OVRANGE_ACT,
  input wire logic [3:0] O_CURRENT_MODE,
  input wire logic O_TOGGLE,
  input wire logic O_SOFT_RESET,
  input wire logic O_FAULT
);
  logic [3:0] volt;
  logic [3:0] curr;

  // Range class per channel, from the code alone; 111 is neither class
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      volt[i] = !O_RANGE_CODE[3*i+2];
      curr[i] = O_RANGE_CODE[3*i+2] && (O_RANGE_CODE[3*i+:2] != 2'h3);
    end
  end

  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RST_B);

  a_ovr_volt_only: assert property (
    O_OVRANGE_ACT == (O_OVRANGE_EN & volt)) else $error("overrange class");
  a_curr_class: assert property (
    O_CURRENT_MODE == curr) else $error("current class");
  a_reset_dflt: assert property (
    !$past(I_RST_B) |-> O_RANGE_CODE == 12'h000 && O_OVRANGE_EN == 4'h0)
    else $error("reset defaults");
  a_soft_pulse: assert property (
    O_SOFT_RESET |=> !O_SOFT_RESET) else $error("soft reset width");
  a_soft_dflt: assert property (
    O_SOFT_RESET |-> O_RANGE_CODE == 12'h000 && O_OVRANGE_EN == 4'h0 &&
    !O_TOGGLE) else $error("soft reset defaults");
  a_fault_pin: assert property (
    O_FAULT == !alert_b) else $error("alert pin");
  a_wdog_off: assert property (
    !I_WDOG_EN && I_CE |=> !O_FAULT) else $error("fault while disabled");
  a_quiet_hold: assert property (
    $changed({O_RANGE_CODE, O_OVRANGE_EN, O_TOGGLE}) |->
    sync_b && $past(sync_b)) else $error("settings moved in frame");
  a_frame_len: assert property (
    $fell(sync_b) |-> ##[63:65] $rose(sync_b)) else $error("frame length");
  a_sclk_idle: assert property (
    sync_b && $past(sync_b) |-> sclk) else $error("sclk idle level");

  // Main scenarios reached
  c_soft: cover property (O_SOFT_RESET);
  c_fault: cover property ($rose(O_FAULT));
  c_ovr: cover property (O_OVRANGE_ACT != 4'h0);
  c_curr: cover property (O_CURRENT_MODE != 4'h0);
endmodule : drs_assertions

`default_nettype wire

// ---- test/testbench.sv ----
// Bench joining host and device ends over the link; AHB-Lite master.
// Assumes a 200-cycle watchdog timeout and a 2-cycle sclk half period.
`timescale 1ns/100ps
`default_nettype none

module testbench
  import drs_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wdog_en = 1'b0;
  logic ce = 1'b1;
  logic hresp;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic irq;
  logic [11:0] rng;
  logic [3:0] ovr_en;
  logic [3:0] ovr_act;
  logic [3:0] cur;
  logic tog;
  logic srst;
  logic fault;
  logic [31:0] rd;
  logic [31:0] r;
  logic [11:0] m_rng = 12'h0;
  logic [3:0] m_ovr = 4'h0;
  logic m_tog = 1'b0;
  logic [16:0] expq[$];
  int failures = 0;
  int cmp_count = 0;

  always #5 clk = ~clk;

  drs_link_if u_drs_link_if ();

  drs_host #(.HALF_CYC(2)) u_drs_host (.I_CLK_SYS(clk), .I_RST_B(rst_b),
    .I_CE(ce), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .O_IRQ(irq),
    .hl(u_drs_link_if));

  drs_dev #(.WDOG_TO_CYC(200)) u_drs_dev (.I_CLK_SYS(clk), .I_RST_B(rst_b),
    .I_CE(ce), .I_WDOG_EN(wdog_en), .dv(u_drs_link_if),
    .O_RANGE_CODE(rng), .O_OVRANGE_EN(ovr_en), .O_OVRANGE_ACT(ovr_act),
    .O_CURRENT_MODE(cur), .O_TOGGLE(tog), .O_SOFT_RESET(srst),
    .O_FAULT(fault));

  drs_assertions u_drs_assertions (.I_CLK_SYS(clk), .I_RST_B(rst_b),
    .I_CE(ce), .I_WDOG_EN(wdog_en), .sclk(u_drs_link_if.sclk),
    .sync_b(u_drs_link_if.sync_b), .alert_b(u_drs_link_if.alert_b),
    .O_RANGE_CODE(rng), .O_OVRANGE_EN(ovr_en), .O_OVRANGE_ACT(ovr_act),
    .O_CURRENT_MODE(cur), .O_TOGGLE(tog), .O_SOFT_RESET(srst),
    .O_FAULT(fault));

  task wrap_up;
    // A note never checked means a frame never closed
    if (expq.size() != 0)
      failures++;
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  task chk_dev(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: settings %h want %h", $time, got, exp);
    end
  endtask : chk_dev

  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: value %h want %h", $time, got, exp);
    end
  endtask : chk_reg

  // One single word transfer; the wait ends only on hready or the timeout
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer

  // Note the expected settings, send a frame, poll busy until it is out
  task send(input logic [15:0] f);
    if (f[15:13] == 3'h4)
      m_tog = f[12];
    if (f[15:13] == 3'h4 && f[11:0] == 12'h555)
    begin
      m_rng = 12'h0;
      m_ovr = 4'h0;
      m_tog = 1'b0;
    end
    if (f[15:13] == 3'h7)
    begin
      m_rng[3*f[12:11]+:3] = f[2:0];
      m_ovr[f[12:11]] = f[3];
    end
    expq.push_back({m_rng, m_ovr, m_tog});
    xfer(1'b1, 8'h00, {16'h0, f});
    do xfer(1'b0, 8'h04, 32'h0); while (rd[0] !== 1'b0);
  endtask : send

  // Settings land one cycle after the frame closes; check the third
  always @(posedge u_drs_link_if.sync_b)
  begin
    repeat (3) @(posedge clk);
    if (rst_b)
      chk_dev({rng, ovr_en, tog}, expq.pop_front());
  end

  // Hang guard, well beyond the expected few thousand cycles
  initial
  begin
    #300000;
    failures++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(1588));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    xfer(1'b0, 8'h04, 32'h0);
    chk_reg(rd, 32'h0);
    chk_reg({31'h0, hresp}, 32'h0);
    chk_dev({rng, ovr_en, tog}, 17'h0);
    xfer(1'b0, 8'h10, 32'h0);
    chk_reg(rd, 32'h0);
    // Every range code once, overrange asked on the odd ones; 111 too
    for (int c = 0; c < 8; c++)
      send({3'h7, c[1:0], 7'h0, c[0], c[2:0]});
    repeat (12)
    begin
      r = $urandom;
      if (r[0])
        send({3'h7, r[12:11], 7'h0, r[3], (r[2:0] == 3'h7) ? 3'h6 : r[2:0]});
      else
        send({3'h4, r[12], 1'b1, r[10:0]});
    end
    send(16'h9123);
    send(16'h9555);
    wdog_en <= 1'b1;
    repeat (4) send(16'h8195);
    chk_reg({31'h0, fault}, 32'h0);
    send(16'h8a5a);
    repeat (160) @(posedge clk);
    chk_reg({31'h0, fault}, 32'h1);
    xfer(1'b0, 8'h04, 32'h0);
    chk_reg(rd, 32'h2);
    xfer(1'b1, 8'h08, 32'h1);
    xfer(1'b0, 8'h08, 32'h0);
    chk_reg(rd, 32'h2);
    chk_reg({31'h0, irq}, 32'h0);
    xfer(1'b1, 8'h0c, 32'h2);
    @(posedge clk);
    chk_reg({31'h0, irq}, 32'h1);
    xfer(1'b1, 8'h08, 32'h2);
    @(posedge clk);
    chk_reg({31'h0, irq}, 32'h0);
    // Clock enable low freezes the fault although the watchdog is off
    ce <= 1'b0;
    wdog_en <= 1'b0;
    repeat (3) @(posedge clk);
    chk_reg({31'h0, fault}, 32'h1);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    chk_reg({31'h0, fault}, 32'h0);
    repeat (5) @(posedge clk);
    wrap_up();
  end
endmodule : testbench

`default_nettype wire
